// ==== rtl/sac_pkg.sv ====
// Shared constants and types for the step attenuator serial control
`default_nettype none
package sac_pkg;
    // Serial frame layout
    localparam int FRAME_BITS = 28;
    localparam int WORD_BITS = 5;
    localparam int NUM_PRESETS = 4;
    localparam int FRAME_MSB = 27;
    localparam int PRESET1_LSB = 8;
    localparam logic [7:0] RESERVED_FILL = 8'h00;
    localparam logic [7:0] GOOD_FRAME_LEN = 8'h1c;

    typedef logic [WORD_BITS-1:0] sac_word_t;
    typedef logic [7:0] sac_count_t;

    // Reset values
    localparam sac_word_t PRESET_RESET = 5'h00;
    localparam logic [27:0] FRAME_RESET = 28'h0000000;
    localparam sac_count_t COUNT_RESET = 8'h00;

    // Host timing: serial clock half period
    localparam int CLK_PERIOD_NS = 8;
    localparam int SCLK_HALF_NS = 32;
    localparam int SCLK_HALF_CYC_INT =
        (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] SCLK_HALF_CYC =
        4'(SCLK_HALF_CYC_INT < 1 ? 1 : SCLK_HALF_CYC_INT);

    // Host register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_PARALLEL = 8'h04;
    localparam logic [7:0] REG_PRESET1 = 8'h08;
    localparam logic [7:0] REG_PRESET2 = 8'h0c;
    localparam logic [7:0] REG_PRESET3 = 8'h10;
    localparam logic [7:0] REG_PRESET4 = 8'h14;
    localparam logic [7:0] REG_SEND = 8'h18;
    localparam logic [7:0] REG_STATUS = 8'h1c;

    // Host register fields
    localparam int CTRL_SOURCE_BIT = 0;
    localparam int CTRL_STATE_LO_BIT = 1;
    localparam int CTRL_STATE_HI_BIT = 2;
    localparam int STATUS_BUSY_BIT = 0;

    // Preset word n (0 = first) out of a full frame
    function automatic sac_word_t sac_preset_field(
        input logic [27:0] frame, input int idx);
        sac_preset_field = frame[PRESET1_LSB + WORD_BITS*idx +: WORD_BITS];
    endfunction
endpackage
`default_nettype wire

// ==== rtl/sac_if.sv ====
// Serial link and control pins between host and attenuator
`default_nettype none
interface sac_if;
    logic sclk;
    logic csN;
    logic sdi;
    logic controlSourceSelect;
    logic stateSelLo;
    logic stateSelHi;
    logic [4:0] parallelAttenInputs;

    // Attenuator end only listens
    modport dev (
        input sclk,
        input csN,
        input sdi,
        input controlSourceSelect,
        input stateSelLo,
        input stateSelHi,
        input parallelAttenInputs
    );

    // Host end drives every pin
    modport host (
        output sclk,
        output csN,
        output sdi,
        output controlSourceSelect,
        output stateSelLo,
        output stateSelHi,
        output parallelAttenInputs
    );
endinterface
`default_nettype wire

// ==== rtl/sac_atten_device.sv ====
// Attenuator end: serial preset loader and attenuation selector
`default_nettype none
module sac_atten_device (
    // Link pins from the host
    sac_if.dev link,
    // System
    input wire logic reset,
    // Applied attenuation code, one bit per stage
    output logic [4:0] attenuatorRfOutput,
    // Stored preset words, index 0 is preset one
    output logic [3:0][4:0] storedPresets,
    // Frame length status
    output logic [7:0] lastFrameLength,
    output logic frameLengthError
);

    // Serial clock domain state
    typedef struct packed {
        logic [27:0] shiftReg;
        sac_pkg::sac_count_t edgeCount;
    } sac_shift_s;

    // Chip select domain state
    typedef struct packed {
        logic [3:0][4:0] presets;
        sac_pkg::sac_count_t prevCount;
        sac_pkg::sac_count_t lastLen;
        logic lenErr;
    } sac_hold_s;

    sac_shift_s shiftQ;
    sac_shift_s next_shiftQ;
    sac_hold_s holdQ;
    sac_hold_s next_holdQ;
    sac_pkg::sac_count_t frameLen;
    logic [1:0] stateIndex;

    // Shift in on each rising serial clock edge while selected.
    // The edge counter is free running and never cleared by the
    // select line, so no asynchronous clear races the load edge;
    // the frame length is the difference between two loads.
    always_comb begin
        next_shiftQ = shiftQ;
        if (!link.csN) begin
            // New bit enters at bit 0, the oldest climbs to 27
            next_shiftQ.shiftReg = {shiftQ.shiftReg[26:0],
                                    link.sdi};
            next_shiftQ.edgeCount = shiftQ.edgeCount + 8'h01;
        end
    end

    // Serial clock only runs inside frames
    always_ff @(posedge link.sclk or posedge reset) begin
        if (reset) begin
            shiftQ.shiftReg <= sac_pkg::FRAME_RESET;
            shiftQ.edgeCount <= sac_pkg::COUNT_RESET;
        end else begin
            shiftQ <= next_shiftQ;
        end
    end

    // Edges seen in the frame that just closed. The counter is
    // quiet here: the host stops the serial clock before it
    // raises select, so this crossing reads a settled value.
    assign frameLen = 8'(shiftQ.edgeCount - holdQ.prevCount);

    // Load the preset words when select rises
    always_comb begin
        next_holdQ = holdQ;
        next_holdQ.prevCount = shiftQ.edgeCount;
        next_holdQ.lastLen = frameLen;
        // A short or long frame is dropped whole, so a glitch on the
        // link never leaves presets half updated.
        if (frameLen == sac_pkg::GOOD_FRAME_LEN) begin
            next_holdQ.lenErr = 1'b0;
            for (int i = 0; i < sac_pkg::NUM_PRESETS; i++) begin
                // Index 0 from bits 12..8 up to index 3 from 27..23
                next_holdQ.presets[i] = sac_pkg::sac_preset_field(
                    shiftQ.shiftReg, i);
            end
        end else begin
            next_holdQ.lenErr = 1'b1;
        end
        // Bits 7..0 are carried in the frame but never used
    end

    // Select line acts as the load clock of the holding words
    always_ff @(posedge link.csN or posedge reset) begin
        if (reset) begin
            holdQ.presets <= {4{sac_pkg::PRESET_RESET}};
            holdQ.prevCount <= sac_pkg::COUNT_RESET;
            holdQ.lastLen <= sac_pkg::COUNT_RESET;
            holdQ.lenErr <= 1'b0;
        end else begin
            holdQ <= next_holdQ;
        end
    end

    // Low pin is the low index bit, high pin the high one
    assign stateIndex = {link.stateSelHi,
                         link.stateSelLo};

    // Pick the attenuation source. This path is purely
    // combinational so a pin change takes effect without any
    // serial clock, at the cost of no registered output here.
    always_comb begin
        if (link.controlSourceSelect) begin
            // Any stored word without a new frame
            attenuatorRfOutput =
                holdQ.presets[stateIndex];
        end else begin
            // Bit n enables the stage of weight 2**n dB
            attenuatorRfOutput =
                link.parallelAttenInputs;
        end
    end

    // Status straight from the holding flip-flops
    assign storedPresets = holdQ.presets;
    assign lastFrameLength = holdQ.lastLen;
    assign frameLengthError = holdQ.lenErr;

endmodule
`default_nettype wire

// ==== rtl/sac_atten_host.sv ====
// Host end: register port that drives the attenuator link
//
// Design decisions made here: the strobed register port and the register offsets.
`default_nettype none
module sac_atten_host (
    // System
    input wire logic clk,
    input wire logic reset,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wrData,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    output logic [31:0] rdData,
    // Link to the attenuator
    sac_if.host link
);

    typedef enum logic [2:0] {
        SAC_IDLE, SAC_LOW, SAC_HIGH, SAC_TAIL, SAC_GAP
    } sac_phase_e;

    typedef struct packed {
        sac_phase_e phase;
        logic [3:0] halfCnt;
        logic [4:0] bitIdx;
        logic [27:0] frame;
        logic [3:0][4:0] presets;
        logic source;
        logic stateLo;
        logic stateHi;
        logic [4:0] parallel;
        logic sclk;
        logic csN;
        logic sdi;
        logic [4:0] parOut;
        logic [31:0] rdData;
    } sac_host_s;

    sac_host_s q;
    sac_host_s n;
    logic halfDone;

    assign halfDone = (q.halfCnt == 4'(sac_pkg::SCLK_HALF_CYC - 4'h1));

    // Register access, frame sequencer and pin drive
    always_comb begin
        n = q;
        n.rdData = 32'h00000000;
        n.halfCnt = halfDone ? 4'h0 : 4'(q.halfCnt + 4'h1);
        if (wrStrobe) begin
            unique case (addr)
                sac_pkg::REG_CTRL: begin
                    n.source = wrData[sac_pkg::CTRL_SOURCE_BIT];
                    n.stateLo = wrData[sac_pkg::CTRL_STATE_LO_BIT];
                    n.stateHi = wrData[sac_pkg::CTRL_STATE_HI_BIT];
                end
                sac_pkg::REG_PARALLEL: n.parallel = wrData[4:0];
                sac_pkg::REG_PRESET1: n.presets[0] = wrData[4:0];
                sac_pkg::REG_PRESET2: n.presets[1] = wrData[4:0];
                sac_pkg::REG_PRESET3: n.presets[2] = wrData[4:0];
                sac_pkg::REG_PRESET4: n.presets[3] = wrData[4:0];
                default: ;
            endcase
        end
        if (rdStrobe) begin
            unique case (addr)
                sac_pkg::REG_CTRL: n.rdData = {29'h0, q.stateHi,
                                               q.stateLo, q.source};
                sac_pkg::REG_PARALLEL: n.rdData = {27'h0, q.parallel};
                sac_pkg::REG_PRESET1: n.rdData = {27'h0, q.presets[0]};
                sac_pkg::REG_PRESET2: n.rdData = {27'h0, q.presets[1]};
                sac_pkg::REG_PRESET3: n.rdData = {27'h0, q.presets[2]};
                sac_pkg::REG_PRESET4: n.rdData = {27'h0, q.presets[3]};
                sac_pkg::REG_STATUS:
                    n.rdData = {31'h0, q.phase != SAC_IDLE};
                default: n.rdData = 32'h00000000;
            endcase
        end
        // Parallel pins forced low while the serial words rule
        n.parOut = n.source ? 5'h00 : n.parallel;
        // Frame sequencer; a send while busy is ignored
        unique case (q.phase)
            SAC_IDLE: begin
                n.halfCnt = 4'h0;
                if (wrStrobe && addr == sac_pkg::REG_SEND) begin
                    n.frame = {q.presets[3], q.presets[2], q.presets[1],
                               q.presets[0],
                               sac_pkg::RESERVED_FILL};
                    n.csN = 1'b0;
                    n.sclk = 1'b0;
                    n.bitIdx = 5'(sac_pkg::FRAME_MSB);
                    n.sdi = n.frame[sac_pkg::FRAME_MSB];
                    n.phase = SAC_LOW;
                end
            end
            SAC_LOW: if (halfDone) begin
                n.sclk = 1'b1;
                n.phase = SAC_HIGH;
            end
            SAC_HIGH: if (halfDone) begin
                n.sclk = 1'b0;
                if (q.bitIdx == 5'h00) begin
                    n.phase = SAC_TAIL;
                end else begin
                    // Next bit set up a full half period before its edge
                    n.bitIdx = 5'(q.bitIdx - 5'h01);
                    n.sdi = q.frame[n.bitIdx];
                    n.phase = SAC_LOW;
                end
            end
            SAC_TAIL: if (halfDone) begin
                n.csN = 1'b1;
                n.sdi = 1'b0;
                n.phase = SAC_GAP;
            end
            SAC_GAP: if (halfDone) begin
                n.phase = SAC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            q <= '0;
            q.phase <= SAC_IDLE;
            q.csN <= 1'b1;
        end else begin
            q <= n;
        end
    end

    // Pins straight from flip-flops
    assign link.sclk = q.sclk;
    assign link.csN = q.csN;
    assign link.sdi = q.sdi;
    assign link.controlSourceSelect = q.source;
    assign link.stateSelLo = q.stateLo;
    assign link.stateSelHi = q.stateHi;
    assign link.parallelAttenInputs = q.parOut;
    assign rdData = q.rdData;

endmodule
`default_nettype wire

// ==== verification/sac_link_asserts.sv ====
// Checker for the link between host and attenuator
`default_nettype none
module sac_link_asserts (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Link pins
    input wire logic sclk,
    input wire logic csN,
    input wire logic sdi,
    input wire logic controlSourceSelect,
    input wire logic stateSelLo,
    input wire logic stateSelHi,
    input wire logic [4:0] parallelAttenInputs,
    // Attenuator outputs
    input wire logic [4:0] attenuatorRfOutput,
    input wire logic [3:0][4:0] storedPresets
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    logic [7:0] nRise;
    logic [27:0] shadow;
    logic [1:0] sel;
    assign sel = {stateSelHi, stateSelLo};
    // Count and capture serial bits; the count is cleared between frames
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            nRise <= 8'h00;
            shadow <= 28'h0000000;
        end else if (csN) begin
            nRise <= 8'h00;
        end else if ($rose(sclk)) begin
            nRise <= nRise + 8'h01;
            shadow <= {shadow[26:0], sdi};
        end
    end
    a_frame_length: assert property ($rose(csN) |-> nRise == 8'h1c)
        else $error("frame length not 28");
    a_sclk_idle: assert property (csN |-> !sclk)
        else $error("serial clock moved outside frame");
    a_reserved_zero: assert property (
        $rose(sclk) && nRise >= 8'h14 |-> !sdi)
        else $error("reserved bit not zero");
    a_load_frame: assert property (
        $rose(csN) |-> storedPresets == shadow[27:8])
        else $error("presets differ from frame");
    a_presets_hold: assert property (
        $stable(csN) |-> $stable(storedPresets))
        else $error("presets changed without select edge");
    a_pick_first: assert property (
        controlSourceSelect && sel == 2'h0 |->
        attenuatorRfOutput == storedPresets[0])
        else $error("preset one not applied");
    a_toggle_lo: assert property (
        controlSourceSelect && sel == 2'h1 |->
        attenuatorRfOutput == storedPresets[1])
        else $error("preset two not applied");
    a_upper_pair: assert property (
        controlSourceSelect && stateSelHi |->
        attenuatorRfOutput == storedPresets[sel])
        else $error("upper preset not applied");
    a_parallel_drive: assert property (
        !controlSourceSelect |-> attenuatorRfOutput == parallelAttenInputs)
        else $error("parallel inputs not applied");
    a_parallel_quiet: assert property (
        controlSourceSelect |-> parallelAttenInputs == 5'h00)
        else $error("parallel inputs not low in serial mode");
    // Main scenarios reached
    c_frame: cover property ($rose(csN));
    c_fourth: cover property (controlSourceSelect && sel == 2'h3);
    c_parallel: cover property (!controlSourceSelect && |parallelAttenInputs);
endmodule
`default_nettype wire

// ==== verification/testbench.sv ====
// Self-checking bench for host and attenuator ends
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, reset, wrStrobe, rdStrobe;
    logic [7:0] addr;
    logic [31:0] wrData, rdData, d;
    logic [4:0] out, out2, v;
    logic [3:0][4:0] pre, pre2, p;
    logic [7:0] len, len2;
    logic lenErr, lenErr2;
    int errors, n_checks, seed, i, k;
    sac_if lnk();
    sac_if lnk2();
    sac_atten_host u_sac_atten_host (.clk(clk), .reset(reset),
        .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
        .rdStrobe(rdStrobe), .rdData(rdData), .link(lnk.host));
    sac_atten_device u_sac_atten_device (.link(lnk.dev), .reset(reset),
        .attenuatorRfOutput(out), .storedPresets(pre),
        .lastFrameLength(len), .frameLengthError(lenErr));
    // Second end fed by the bench with rule-breaking frames
    sac_atten_device u_sac_atten_device_b (.link(lnk2.dev), .reset(reset),
        .attenuatorRfOutput(out2), .storedPresets(pre2),
        .lastFrameLength(len2), .frameLengthError(lenErr2));
    sac_link_asserts u_sac_link_asserts (.clk(clk), .reset(reset),
        .sclk(lnk.sclk), .csN(lnk.csN), .sdi(lnk.sdi),
        .controlSourceSelect(lnk.controlSourceSelect),
        .stateSelLo(lnk.stateSelLo), .stateSelHi(lnk.stateSelHi),
        .parallelAttenInputs(lnk.parallelAttenInputs),
        .attenuatorRfOutput(out), .storedPresets(pre));
    // Expected applied word for a select code
    function automatic logic [4:0] pick(logic [3:0][4:0] q, logic [1:0] s);
        return q[s];
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    // Idle cycle after each strobe keeps one assignment per step
    task automatic wr(input logic [7:0] a, input logic [31:0] x);
        addr <= a;
        wrData <= x;
        wrStrobe <= 1'b1;
        @(posedge clk);
        wrStrobe <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a);
        addr <= a;
        rdStrobe <= 1'b1;
        @(posedge clk);
        rdStrobe <= 1'b0;
        // Read data stand in the cycle after the strobe only
        @(posedge clk);
        d = rdData;
    endtask
    // Serial clock 64 ns, only inside the frame
    // Only the first nb bits are sent, so short frames can be made
    task automatic raw(input logic [27:0] f, input int nb);
        lnk2.csN <= 1'b0;
        for (int b = 27; b > 27 - nb; b--) begin
            lnk2.sdi <= f[b];
            repeat (4) @(posedge clk);
            lnk2.sclk <= 1'b1;
            repeat (4) @(posedge clk);
            lnk2.sclk <= 1'b0;
        end
        repeat (4) @(posedge clk);
        lnk2.csN <= 1'b1;
        lnk2.sdi <= ~f[0];
        @(posedge clk);
    endtask
    task automatic end_sim();
        if (errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Watchdog well beyond the expected run
    initial begin
        #200000;
        errors++;
        end_sim();
    end
    initial begin
        seed = 53077;
        errors = 0;
        n_checks = 0;
        reset = 1'b1;
        addr = 8'h00;
        wrData = 32'h00000000;
        wrStrobe = 1'b0;
        rdStrobe = 1'b0;
        lnk2.sclk = 1'b0;
        lnk2.csN = 1'b1;
        lnk2.sdi = 1'b0;
        lnk2.controlSourceSelect = 1'b1;
        lnk2.stateSelLo = 1'b0;
        lnk2.stateSelHi = 1'b0;
        lnk2.parallelAttenInputs = 5'h00;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rd(8'h20);
        chk("unmapped", 32'h0, d);
        for (k = 0; k < 6; k++) begin
            p = {5'h10, 5'h01, 5'h1f, 5'h00};
            for (i = 0; i < 4 && k > 0; i++) p[i] = 5'($random(seed));
            for (i = 0; i < 4; i++) begin
                wr(sac_pkg::REG_PRESET1 + 8'(4 * i), {27'h0, p[i]});
                rd(sac_pkg::REG_PRESET1 + 8'(4 * i));
                chk("preset reg", {27'h0, p[i]}, d);
            end
            wr(sac_pkg::REG_SEND, 32'h0);
            for (i = 0; i < 200; i++) begin
                rd(sac_pkg::REG_STATUS);
                if (d[0] !== 1'b1) break;
            end
            chk("busy", 32'h0, d);
            chk("presets", {12'h0, p}, {12'h0, pre});
            chk("frame length", 32'h1c, {24'h0, len});
            chk("length error", 32'h0, {31'h0, lenErr});
            for (i = 0; i < 4; i++) begin
                wr(sac_pkg::REG_CTRL, {29'h0, i[1], i[0], 1'b1});
                chk("serial out", {27'h0, pick(p, 2'(i))}, {27'h0, out});
            end
            v = (k == 0) ? 5'h1f : 5'($random(seed));
            wr(sac_pkg::REG_CTRL, 32'h0);
            wr(sac_pkg::REG_PARALLEL, {27'h0, v});
            chk("parallel out", {27'h0, v}, {27'h0, out});
            wr(sac_pkg::REG_PARALLEL, 32'h0);
        end
        for (i = 0; i < 4; i++) p[i] = 5'($random(seed));
        raw({p, 8'ha5}, 28);
        chk("reserved ignored", {12'h0, p}, {12'h0, pre2});
        chk("applied on rise", {27'h0, p[0]}, {27'h0, out2});
        chk("good length", 32'h1c, {24'h0, len2});
        // Short frame must be dropped whole
        raw(~{p, 8'h00}, 20);
        chk("short dropped", {12'h0, p}, {12'h0, pre2});
        chk("short length", 32'h14, {24'h0, len2});
        chk("short flagged", 32'h1, {31'h0, lenErr2});
        end_sim();
    end
endmodule
`default_nettype wire
